// File: rtl/dpsb_pkg.sv
// Shared constants and pin bundles of the dual-port burst SRAM block.
package dpsb_pkg;
  localparam int DPSB_WORD_W = 36;
  localparam int DPSB_ADDR_MAX_W = 15;
  localparam int DPSB_NPORT = 2;
  localparam int DPSB_LEFT = 0;
  localparam int DPSB_RIGHT = 1;
  localparam int DPSB_LANE_W = 9;
  localparam int DPSB_NLANE = 4;
  localparam int DPSB_HALF_W = 18;
  localparam int DPSB_AXI_AW = 6;
  localparam logic [5:0] DPSB_OFF_CTRL = 6'h00;
  localparam logic [5:0] DPSB_OFF_STATUS = 6'h04;
  localparam logic [5:0] DPSB_OFF_CNT0 = 6'h08;
  localparam logic [5:0] DPSB_OFF_CNT1 = 6'h0C;
  localparam int DPSB_CTRL_W = 4;
  localparam logic [3:0] DPSB_CTRL_RST = 4'h0;
  localparam int DPSB_CTRL_RB_LSB = 0;
  localparam int DPSB_CTRL_WID_LSB = 2;
  localparam int DPSB_STAT_PD_LSB = 0;
  localparam int DPSB_STAT_MODE_LSB = 2;
  localparam logic [1:0] DPSB_WID_X36 = 2'h0;
  localparam logic [1:0] DPSB_WID_X18 = 2'h1;
  localparam logic [1:0] DPSB_WID_X9 = 2'h2;
  localparam logic [1:0] DPSB_RESP_OKAY = 2'h0;
  localparam logic [1:0] DPSB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic link_clk;
    logic [DPSB_ADDR_MAX_W-1:0] addr;
    logic addr_load_strobe_n;
    logic counter_advance_n;
    logic counter_clear_n;
    logic chip_enable_n;
    logic read_write;
    logic output_enable_n;
    logic output_mode_select_pin;
    logic [DPSB_NLANE-1:0] byte_select_n;
    logic [DPSB_WORD_W-1:0] dq_in;
  } dpsb_pin_in_t;

  typedef struct packed {
    logic [DPSB_WORD_W-1:0] dq_out;
    logic [DPSB_WORD_W-1:0] dq_oe;
  } dpsb_pin_out_t;
endpackage

// File: rtl/dpsb_top.sv
// Dual-port synchronous SRAM with burst counters and an AXI4-Lite control slave.
// How it works
// R1: One shared array of 16K or 32K words, 36 bits each.
// R2: Both ports read and write independently, same cycle, any address.
// R3: Each port captures control, address and write data on its clock's rising edge.
// R4: Pipelined mode sends read data through a port-clocked output register.
// R5: Flow-through mode bypasses that register, data comes within the cycle.
// R6: Each port picks its output mode from its own mode select pin.
// R7: Mode select low means flow-through, high means pipelined.
// R8: The internal write strobe is self-timed, not stretched by the outside strobe.
// R9: Outside party drives read-write low to write, high to read.
// R10: Chip enable sampled high for one cycle powers the port down.
// R11: Pipelined outputs stay off for one cycle after chip enable returns low.
// R12: Each port has its own burst counter loaded from the external address.
// R13: Counter loads only when address strobe and counter enable are both low.
// R14: While counting, the external address pins are ignored.
// R15: While counting, the counter steps once per port clock edge in x36 width, and once per last slice in the 18-bit and 9-bit slice widths.
// R16: The counter spans the whole array and wraps to zero.
// R17: Counter clear resets the port's burst counter.
// R18: Low counter clear forces zero and beats strobe and counter enable.
// R19: Burst counting works in both output modes.
// R20: The counter value can be read back over the port's data lines.
// R21: The right port can carry the word as 18-bit or 9-bit slices.
// R22: The left port has byte selects for reads and writes.
// R23: With no strobe, count or clear, the counter holds its value.
// R24: Pipelined read data appears after the edge following the address edge.
`timescale 1ns/1ps
module dpsb_top
  import dpsb_pkg::*;
#(
  parameter int ADDR_W = DPSB_ADDR_MAX_W
)
(
  input logic CLK,
  input logic RESETN,
  input logic [DPSB_AXI_AW-1:0] S_AXI_AWADDR,
  input logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input logic [31:0] S_AXI_WDATA,
  input logic [3:0] S_AXI_WSTRB,
  input logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [DPSB_AXI_AW-1:0] S_AXI_ARADDR,
  input logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input dpsb_pin_in_t [DPSB_NPORT-1:0] PORT_PINS,
  output dpsb_pin_out_t [DPSB_NPORT-1:0] PORT_DQ
);

  localparam int DEPTH = 1 << ADDR_W;

  // Bit mask of the slice that a narrow transfer uses.
  function automatic logic [DPSB_WORD_W-1:0] slice_mask(input logic [1:0] wid, input logic [1:0] sub);
    logic [DPSB_WORD_W-1:0] m;
    m = '1;
    if (wid == DPSB_WID_X18)
    begin
      m = {{DPSB_HALF_W{1'b0}}, {DPSB_HALF_W{1'b1}}} << (sub[0] * DPSB_HALF_W);
    end
    else if (wid == DPSB_WID_X9)
    begin
      m = {{(DPSB_WORD_W-DPSB_LANE_W){1'b0}}, {DPSB_LANE_W{1'b1}}} << (sub * DPSB_LANE_W);
    end
    return m;
  endfunction

  // Bit offset of the slice that a narrow transfer uses.
  function automatic int slice_shift(input logic [1:0] wid, input logic [1:0] sub);
    int s;
    s = 0;
    if (wid == DPSB_WID_X18)
    begin
      s = sub[0] * DPSB_HALF_W;
    end
    else if (wid == DPSB_WID_X9)
    begin
      s = sub * DPSB_LANE_W;
    end
    return s;
  endfunction

  // Expands active-low byte selects to a 36-bit lane mask.
  function automatic logic [DPSB_WORD_W-1:0] lane_mask(input logic [DPSB_NLANE-1:0] sel_n);
    logic [DPSB_WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < DPSB_NLANE; i++)
    begin
      m[i*DPSB_LANE_W +: DPSB_LANE_W] = {DPSB_LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  logic [DPSB_WORD_W-1:0] mem [DEPTH];
  logic [DPSB_CTRL_W-1:0] ctrl;
  logic [DPSB_NPORT-1:0] wr_en;
  logic [ADDR_W-1:0] wr_addr [DPSB_NPORT];
  logic [DPSB_WORD_W-1:0] wr_data [DPSB_NPORT];
  logic [DPSB_WORD_W-1:0] wr_mask [DPSB_NPORT];
  logic [ADDR_W-1:0] cnt_val [DPSB_NPORT];
  logic [DPSB_NPORT-1:0] pd_val;
  logic [DPSB_NPORT-1:0] mode_val;

  for (genvar p = 0; p < DPSB_NPORT; p++)
  begin : g_port
    dpsb_pin_in_t s1;
    dpsb_pin_in_t s2;
    logic clk_prev;
    logic edge_hit;
    logic go;
    logic pd;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] next_acc;
    logic [1:0] sub;
    logic [1:0] sub_cap;
    logic [1:0] wid;
    logic narrow;
    logic last;
    logic live;
    logic rd_cap;
    logic wr_cap;
    logic flow_en;
    logic pipe_en;
    logic [DPSB_WORD_W-1:0] wdata_cap;
    logic [DPSB_WORD_W-1:0] mask_cap;
    logic [DPSB_WORD_W-1:0] flow_q;
    logic [DPSB_WORD_W-1:0] flow_mask;
    logic [DPSB_WORD_W-1:0] pipe_q;
    logic [DPSB_WORD_W-1:0] pipe_mask;
    dpsb_pin_out_t dq;

    // Two-stage synchroniser for every pin, the port clock included.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        s1 <= '0;
        s2 <= '0;
        clk_prev <= 1'b0;
      end
      else
      begin
        s1 <= PORT_PINS[p];
        s2 <= s1;
        clk_prev <= s2.link_clk;
      end
    end

    assign edge_hit = s2.link_clk & ~clk_prev;
    assign wid = (p == DPSB_RIGHT) ? ctrl[DPSB_CTRL_WID_LSB +: 2] : DPSB_WID_X36;
    assign narrow = (wid == DPSB_WID_X18) || (wid == DPSB_WID_X9);
    assign last = !narrow || (wid == DPSB_WID_X18 && sub[0]) || (wid == DPSB_WID_X9 && sub == 2'h3);
    assign live = !s2.chip_enable_n;

    always_comb
    begin
      if (!s2.counter_clear_n)
      begin
        next_acc = '0;
      end
      else if (!s2.addr_load_strobe_n)
      begin
        next_acc = s2.addr[ADDR_W-1:0];
      end
      else if (!s2.counter_advance_n && live && !narrow)
      begin
        next_acc = cnt + 1'b1; // [R15]
      end
      else
      begin
        next_acc = cnt; // [R14]
      end
    end

    // Burst counter, stepped on the sampled port clock edge.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        cnt <= '0;
        sub <= '0;
      end
      else if (edge_hit)
      begin
        if (!s2.counter_clear_n)
        begin
          cnt <= '0; // [R17] [R18]
          sub <= '0;
        end
        else if (!s2.addr_load_strobe_n && !s2.counter_advance_n)
        begin
          cnt <= s2.addr[ADDR_W-1:0]; // [R12] [R13]
          sub <= '0;
        end
        else if (live)
        begin
          if (narrow)
          begin
            sub <= last ? 2'h0 : sub + 2'h1; // [R21]
          end
          if (!s2.counter_advance_n && last)
          begin
            cnt <= cnt + 1'b1; // [R15] [R16] [R19]
          end
        end
      end
    end

    // Input registers and power-down flag.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        acc_addr <= '0;
        rd_cap <= 1'b0;
        wr_cap <= 1'b0;
        wdata_cap <= '0;
        mask_cap <= '0;
        sub_cap <= '0;
        pd <= 1'b0;
        go <= 1'b0;
      end
      else
      begin
        go <= edge_hit;
        if (edge_hit)
        begin
          acc_addr <= next_acc; // [R3]
          rd_cap <= live && s2.read_write; // [R9]
          wr_cap <= live && !s2.read_write;
          wdata_cap <= s2.dq_in << slice_shift(wid, sub);
          mask_cap <= slice_mask(wid, sub) & ((p == DPSB_LEFT) ? lane_mask(s2.byte_select_n) : '1); // [R22]
          sub_cap <= sub;
          pd <= s2.chip_enable_n; // [R10]
        end
      end
    end

    // Array read one cycle after capture, or counter read back.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        flow_en <= 1'b0;
        flow_q <= '0;
        flow_mask <= '0;
      end
      else if (go)
      begin
        flow_en <= rd_cap;
        if (ctrl[DPSB_CTRL_RB_LSB + p])
        begin
          flow_q <= DPSB_WORD_W'(cnt); // [R20]
        end
        else
        begin
          flow_q <= mem[acc_addr] >> slice_shift(wid, sub_cap); // [R21]
        end
        flow_mask <= narrow ? slice_mask(wid, 2'h0) : mask_cap;
      end
    end

    // Pipeline output register on the port clock.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        pipe_en <= 1'b0;
        pipe_q <= '0;
        pipe_mask <= '0;
      end
      else if (edge_hit)
      begin
        pipe_q <= flow_q; // [R4] [R24]
        pipe_en <= flow_en && !pd; // [R11]
        pipe_mask <= flow_mask;
      end
    end

    // Pin drivers.
    always_ff @(posedge CLK)
    begin
      if (!RESETN)
      begin
        dq <= '0;
      end
      else if (s2.output_mode_select_pin)
      begin
        dq.dq_out <= pipe_q; // [R6] [R7] [R4]
        dq.dq_oe <= (pipe_en && !pd && !s2.output_enable_n) ? pipe_mask : '0; // [R11]
      end
      else
      begin
        dq.dq_out <= flow_q; // [R5] [R7]
        dq.dq_oe <= (flow_en && !pd && !s2.output_enable_n) ? flow_mask : '0;
      end
    end

    assign PORT_DQ[p] = dq;
    assign wr_en[p] = go && wr_cap;
    assign wr_addr[p] = acc_addr;
    assign wr_data[p] = wdata_cap;
    assign wr_mask[p] = mask_cap;
    assign cnt_val[p] = cnt;
    assign pd_val[p] = pd;
    assign mode_val[p] = s2.output_mode_select_pin;
  end

  // Shared array; one self-timed write per port per capture.
  always_ff @(posedge CLK)
  begin
    for (int p = 0; p < DPSB_NPORT; p++)
    begin
      if (wr_en[p])
      begin
        mem[wr_addr[p]] <= (mem[wr_addr[p]] & ~wr_mask[p]) | (wr_data[p] & wr_mask[p]); // [R1] [R2] [R8]
      end
    end
  end

  logic aw_got;
  logic w_got;
  logic [DPSB_AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [5:0] waddr_w;
  logic [5:0] raddr_w;
  logic [31:0] rd_value;
  logic [1:0] rd_resp;

  assign waddr_w = {awaddr_q[DPSB_AXI_AW-1:2], 2'b00};
  assign raddr_w = {S_AXI_ARADDR[DPSB_AXI_AW-1:2], 2'b00};

  // AXI4-Lite write channel.
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= DPSB_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      ctrl <= DPSB_CTRL_RST;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_got && w_got && !S_AXI_BVALID)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= DPSB_RESP_OKAY;
        if (waddr_w == DPSB_OFF_CTRL)
        begin
          if (wstrb_q[0])
          begin
            ctrl <= wdata_q[DPSB_CTRL_W-1:0];
          end
        end
        else if (waddr_w == DPSB_OFF_STATUS || waddr_w == DPSB_OFF_CNT0 || waddr_w == DPSB_OFF_CNT1)
        begin
          S_AXI_BRESP <= DPSB_RESP_OKAY;
        end
        else
        begin
          S_AXI_BRESP <= DPSB_RESP_SLVERR;
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Read decode.
  always_comb
  begin
    rd_value = '0;
    rd_resp = DPSB_RESP_OKAY;
    if (raddr_w == DPSB_OFF_CTRL)
    begin
      rd_value = 32'(ctrl);
    end
    else if (raddr_w == DPSB_OFF_STATUS)
    begin
      rd_value[DPSB_STAT_PD_LSB +: DPSB_NPORT] = pd_val;
      rd_value[DPSB_STAT_MODE_LSB +: DPSB_NPORT] = mode_val;
    end
    else if (raddr_w == DPSB_OFF_CNT0)
    begin
      rd_value = 32'(cnt_val[DPSB_LEFT]);
    end
    else if (raddr_w == DPSB_OFF_CNT1)
    begin
      rd_value = 32'(cnt_val[DPSB_RIGHT]);
    end
    else
    begin
      rd_resp = DPSB_RESP_SLVERR;
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= DPSB_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_value;
      S_AXI_RRESP <= rd_resp;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// File: tb/dpsb_chk.sv
// Concurrent checks on the ports of the dual-port burst SRAM top.
`timescale 1ns/1ps
module dpsb_chk
  import dpsb_pkg::*;
#(
  parameter int ADDR_W = DPSB_ADDR_MAX_W
)
(
  input logic CLK,
  input logic RESETN,
  input logic [DPSB_AXI_AW-1:0] S_AXI_AWADDR,
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic [1:0] S_AXI_BRESP,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [DPSB_AXI_AW-1:0] S_AXI_ARADDR,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic [1:0] S_AXI_RRESP,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input dpsb_pin_in_t [DPSB_NPORT-1:0] PORT_PINS,
  input dpsb_pin_out_t [DPSB_NPORT-1:0] PORT_DQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic prev_lk;
  logic [7:0] rise_hist;
  // Records recent rising edges of the left port clock.
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      prev_lk <= 1'b0;
      rise_hist <= 8'h00;
    end
    else
    begin
      prev_lk <= PORT_PINS[0].link_clk;
      rise_hist <= {rise_hist[6:0], PORT_PINS[0].link_clk & ~prev_lk};
    end
  end
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_bvalid_soon: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rvalid_next: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read data late");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_aw_blocked: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("second write accepted");
  a_ar_blocked: assert property (rd_taken |=> !S_AXI_ARREADY)
    else $error("second read accepted");
  a_unmapped_rd: assert property (rd_taken and S_AXI_ARADDR >= 6'h10
    |=> S_AXI_RRESP == DPSB_RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answered wrongly");
  a_unmapped_wr: assert property (wr_taken and S_AXI_AWADDR >= 6'h10
    |-> ##[1:2] (S_AXI_BVALID && S_AXI_BRESP == DPSB_RESP_SLVERR))
    else $error("unmapped write answered wrongly");
  a_dq_after_edge: assert property ($changed(PORT_DQ[0].dq_oe) |-> |rise_hist[6:2])
    else $error("data drive changed without port clock edge");
endmodule
bind dpsb_top dpsb_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PORT_PINS(PORT_PINS), .PORT_DQ(PORT_DQ));

// File: tb/dpsb_port_bfm.sv
// Synchronous bus master model for one memory port.
`timescale 1ns/1ps
module dpsb_port_bfm
  import dpsb_pkg::*;
(
  input logic clk,
  output dpsb_pin_in_t pins,
  input dpsb_pin_out_t dq
);
  initial
  begin
    pins = '1;
    pins.link_clk = 1'b0;
    pins.output_enable_n = 1'b0;
    pins.byte_select_n = 4'h0;
  end
  // One 80 ns port cycle; returns the bus sampled 7 clocks after the previous port edge.
  // Code c is {mode, chip_enable_n, strobe_n, advance_n, clear_n, read_write}.
  task automatic cyc(input logic [5:0] c, input logic [14:0] a, input logic [35:0] d,
    output logic [35:0] q, output logic [35:0] oe);
    @(posedge clk);
    pins.link_clk <= 1'b0;
    pins.output_mode_select_pin <= c[5];
    pins.chip_enable_n <= c[4];
    pins.addr_load_strobe_n <= c[3];
    pins.counter_advance_n <= c[2];
    pins.counter_clear_n <= c[1];
    pins.read_write <= c[0];
    pins.addr <= a;
    pins.dq_in <= c[0] ? ~pins.dq_in : d;
    repeat (3) @(posedge clk);
    q = dq.dq_out;
    oe = dq.dq_oe;
    @(posedge clk);
    pins.link_clk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the dual-port burst SRAM top.
`timescale 1ns/1ps
module tb_top;
  import dpsb_pkg::*;
  localparam logic [5:0] WR = 6'h06;
  localparam logic [5:0] RD = 6'h07;
  localparam logic [5:0] LDW = 6'h02;
  localparam logic [5:0] BW = 6'h0A;
  localparam logic [5:0] HOLD = 6'h0F;
  localparam logic [5:0] CLR = 6'h01;
  localparam logic [5:0] PD = 6'h1F;
  localparam logic [5:0] PIPE = 6'h20;
  localparam logic [35:0] ONES = 36'hFFFFFFFFF;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  dpsb_pin_in_t lp_pins, rp_pins;
  dpsb_pin_out_t [1:0] port_dq;
  logic [35:0] q, oe, q2, oe2, s;
  int bad_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  dpsb_top #(.ADDR_W(14)) dut (.CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PORT_PINS({rp_pins, lp_pins}),
    .PORT_DQ(port_dq));
  dpsb_port_bfm lp (.clk(clk), .pins(lp_pins), .dq(port_dq[0]));
  dpsb_port_bfm rp (.clk(clk), .pins(rp_pins), .dq(port_dq[1]));
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic axi_rd(input logic [5:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    s = {4'h0, rdata};
    r = rresp;
  endtask
  task automatic t_regs;
    axi_rd(DPSB_OFF_CTRL);
    chk("ctrl reset", 36'h0, s);
    axi_rd(6'h10);
    chk("unmapped read data", 36'h0, s);
    chk("unmapped read resp", 36'(DPSB_RESP_SLVERR), 36'(r));
    axi_wr(6'h14, 32'hFFFFFFFF);
    chk("unmapped write resp", 36'(DPSB_RESP_SLVERR), 36'(r));
    axi_wr(DPSB_OFF_CNT0, 32'h00000123);
    chk("counter write resp", 36'(DPSB_RESP_OKAY), 36'(r));
    axi_rd(DPSB_OFF_CNT0);
    chk("counter read only", 36'h0, s);
    axi_wr(DPSB_OFF_CTRL, 32'h0000000F);
    axi_rd(DPSB_OFF_CTRL);
    chk("ctrl write", 36'hF, s);
    axi_wr(DPSB_OFF_CTRL, 32'h00000000);
  endtask
  task automatic t_flow_dual;
    lp.cyc(WR, 15'h0005, 36'h9A5A50123, q, oe);
    fork
      lp.cyc(RD, 15'h0005, 36'h0, q, oe);
      rp.cyc(RD, 15'h0005, 36'h0, q2, oe2);
    join
    fork
      lp.cyc(RD, 15'h0005, 36'h0, q, oe);
      rp.cyc(RD, 15'h0005, 36'h0, q2, oe2);
    join
    chk("left flow read", 36'h9A5A50123, q);
    chk("left drive", ONES, oe);
    chk("right same word", 36'h9A5A50123, q2);
    chk("right drive", ONES, oe2);
  endtask
  task automatic t_burst;
    lp.cyc(LDW, 15'h3FFE, 36'h000000011, q, oe);
    lp.cyc(BW, 15'h1234, 36'h000000022, q, oe);
    lp.cyc(BW, 15'h1234, 36'h000000033, q, oe);
    lp.cyc(BW, 15'h1234, 36'h000000044, q, oe);
    lp.cyc(RD, 15'h3FFF, 36'h0, q, oe);
    axi_rd(DPSB_OFF_CNT0);
    chk("counter after wrap", 36'h1, s);
    lp.cyc(RD, 15'h0000, 36'h0, q, oe);
    chk("top word", 36'h000000022, q);
    lp.cyc(HOLD, 15'h1234, 36'h0, q, oe);
    chk("wrapped word", 36'h000000033, q);
    lp.cyc(RD, 15'h3FFE, 36'h0, q, oe);
    chk("held counter word", 36'h000000044, q);
    lp.cyc(RD, 15'h3FFE, 36'h0, q, oe);
    chk("loaded word", 36'h000000011, q);
  endtask
  task automatic t_clear;
    lp.cyc(CLR, 15'h2222, 36'h0, q, oe);
    lp.cyc(HOLD, 15'h2222, 36'h0, q, oe);
    chk("clear wins", 36'h000000033, q);
    axi_rd(DPSB_OFF_CNT0);
    chk("counter cleared", 36'h0, s);
    axi_wr(DPSB_OFF_CTRL, 32'h00000001);
    lp.cyc(HOLD, 15'h2222, 36'h0, q, oe);
    lp.cyc(HOLD, 15'h2222, 36'h0, q, oe);
    chk("counter on data lines", 36'h0, q);
    axi_wr(DPSB_OFF_CTRL, 32'h00000000);
  endtask
  task automatic t_narrow;
    axi_wr(DPSB_OFF_CTRL, 32'h00000004);
    rp.cyc(WR, 15'h0040, 36'h00003ABCD, q2, oe2);
    rp.cyc(WR, 15'h0040, 36'h00001F0F0, q2, oe2);
    axi_wr(DPSB_OFF_CTRL, 32'h00000000);
    lp.pins.byte_select_n <= 4'h1;
    lp.cyc(WR, 15'h0005, 36'h000000000, q, oe);
    lp.pins.byte_select_n <= 4'h0;
    lp.cyc(RD, 15'h0040, 36'h0, q, oe);
    lp.cyc(RD, 15'h0005, 36'h0, q, oe);
    chk("half slices", 36'h7C3C3ABCD, q);
    lp.cyc(RD, 15'h0005, 36'h0, q, oe);
    chk("byte lanes", 36'h000000123, q);
  endtask
  task automatic t_pipe_pd;
    lp.cyc(PIPE | RD, 15'h0005, 36'h0, q, oe);
    lp.cyc(PIPE | PD, 15'h0005, 36'h0, q, oe);
    lp.cyc(PIPE | PD, 15'h0005, 36'h0, q, oe);
    chk("power down drive", 36'h0, oe);
    axi_rd(DPSB_OFF_STATUS);
    chk("status", 36'h5, s);
    lp.cyc(PIPE | RD, 15'h3FFF, 36'h0, q, oe);
    lp.cyc(PIPE | HOLD, 15'h0000, 36'h0, q, oe);
    chk("dark cycle", 36'h0, oe);
    lp.cyc(PIPE | HOLD, 15'h0000, 36'h0, q, oe);
    chk("pipelined data", 36'h000000022, q);
    chk("pipelined drive", ONES, oe);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_flow_dual;
    t_burst;
    t_clear;
    t_narrow;
    t_pipe_pd;
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
endmodule
